// ### mgmt_host.sv
/* Management host model: single-word writes and reads on the strobe
   bus. Assumes the bank answers a read one cycle after the strobe. */
`timescale 1ns/1ps
module mgmt_host (
	input  wire logic        sys_clk_i,
	input  wire logic [15:0] reg_rdata_i,
	input  wire logic        reg_rvalid_i,
	output logic      [15:0] reg_addr_o,
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	output logic      [15:0] reg_wdata_o
);
	// Bus idle at time zero
	initial begin
		reg_addr_o  = 16'h0000;
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
		reg_wdata_o = 16'h0000;
	end

	// Released lines show the inverse so stale values never pass
	task wr_word(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_wr_o    <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_o    <= 1'b0;
		reg_addr_o  <= ~a;
		reg_wdata_o <= ~d;
	endtask : wr_word

	// A missing answer returns unknown, which no expectation matches
	task rd_word(input logic [15:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		reg_addr_o <= a;
		reg_rd_o   <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_o   <= 1'b0;
		reg_addr_o <= ~a;
		@(posedge sys_clk_i);
		d = reg_rvalid_i ? reg_rdata_i : 16'hxxxx;
	endtask : rd_word
endmodule : mgmt_host

// ### phy_vendor_cfg_pkg.sv
/*
 * Constants for the vendor configuration and status register bank:
 * register offsets, reset values, write masks, field positions and
 * cycle counts. Assumes a 125 MHz core clock and an extended
 * management address of 16 bits handed over by the serial front end.
 *
// Summary of operation
// - Strap flags 15-12 read-only, 1 means enabled
// - Latched interface select at bits 8-6
// - Latched link role at bit 5
// - Latched management address at bits 4-0
// - Managed-mode strap bit 0, rest zero
// - Start bit launches monitor, then self-clears
// - Periodic bit repeats iterations, else one shot
// - Monitor reset bit holds monitor in reset
// - Force-start runs monitor without link
// - Discard two or four samples, bit 7
// - Average two or four samples, bit 6
// - Converter clock divider field, bits 5-4
// - Bypass mode drives sensor reset and select
// - Debug selector picks converter output for readout
// - Break-link FIFO reset allowed by bit 12
// - Slave sends training signalling 32 times
// - Bit 15 bypasses the FEC decoder
// - Outgoing wake and sleep control codes
// - Expected wake and sleep control codes
// - Wake flagged after threshold consecutive codes
// - Sleep flagged after threshold consecutive codes
// - Max-wait timer counts 16 us units
// - Min-wait timer counts 16 us units
 */
package phy_vendor_cfg_pkg;

	// Register offsets
	localparam logic [15:0] OFS_STRAP_ONE      = 16'h045d;
	localparam logic [15:0] OFS_STRAP_TWO      = 16'h045e;
	localparam logic [15:0] OFS_MON_GAIN       = 16'h0467;
	localparam logic [15:0] OFS_MON_DECIM      = 16'h0468;
	localparam logic [15:0] OFS_MON_RUN        = 16'h046a;
	localparam logic [15:0] OFS_MON_READOUT    = 16'h047b;
	localparam logic [15:0] OFS_BREAK_TIMER    = 16'h050a;
	localparam logic [15:0] OFS_FEC_DECODER    = 16'h0510;
	localparam logic [15:0] OFS_LP_CODE_SEL    = 16'h0514;
	localparam logic [15:0] OFS_LP_CODE_THR    = 16'h0515;
	localparam logic [15:0] OFS_MAXWAIT        = 16'h0518;
	localparam logic [15:0] OFS_GIG_LINK_CTRL  = 16'h0519;

	// Reset values
	localparam logic [15:0] RST_MON_GAIN       = 16'h0012;
	localparam logic [15:0] RST_MON_DECIM      = 16'h0920;
	localparam logic [15:0] RST_MON_RUN        = 16'h0094;
	localparam logic [15:0] RST_BREAK_TIMER    = 16'h112e;
	localparam logic [15:0] RST_FEC_DECODER    = 16'h2d50;
	localparam logic [15:0] RST_LP_CODE_SEL    = 16'h08e3;
	localparam logic [15:0] RST_LP_CODE_THR    = 16'h0808;
	localparam logic [15:0] RST_MAXWAIT        = 16'h17ce;
	localparam logic [15:0] RST_GIG_LINK_CTRL  = 16'h003d;

	// Writable bits; everything else reads as stored zero
	localparam logic [15:0] WM_MON_RUN         = 16'h01ff;
	localparam logic [15:0] WM_LP_CODE_SEL     = 16'h0fff;
	localparam logic [15:0] WM_LP_CODE_THR     = 16'h7f7f;
	localparam logic [15:0] WM_GIG_LINK_CTRL   = 16'h7fff;

	// Run control field positions
	localparam int B_START    = 0;
	localparam int B_PERIODIC = 1;
	localparam int B_MON_RST  = 2;
	localparam int B_FORCE    = 3;
	localparam int B_DIV_LO   = 4;
	localparam int B_AVG4     = 6;
	localparam int B_DISC4    = 7;
	localparam int B_HIST_CLR = 8;

	// Other field positions
	localparam int B_BYP_SENSOR_RST = 15;
	localparam int B_DBG_SEL_LO     = 12;
	localparam int B_FIFO_RST_BRK   = 12;
	localparam int B_SEND32         = 11;
	localparam int B_FEC_SKIP       = 15;
	localparam int B_TX_WAKE_LO     = 9;
	localparam int B_TX_SLEEP_LO    = 6;
	localparam int B_RX_WAKE_LO     = 3;
	localparam int B_WAKE_THR_LO    = 8;

	// Converter clock half periods in core cycles (8 ns)
	localparam logic [4:0] HALF_12M5 = 5'h05;
	localparam logic [4:0] HALF_6M25 = 5'h0a;
	localparam logic [4:0] HALF_3M13 = 5'h14;

	// Link-up timer unit
	localparam int CLK_MHZ         = 125;
	localparam int TIMER_UNIT_US   = 16;
	localparam int UNIT_CYCLES     = TIMER_UNIT_US * CLK_MHZ;

	// Strap capture waits for the synchroniser to fill
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	typedef enum logic [1:0] {
		MON_IDLE,
		MON_DISCARD,
		MON_AVERAGE,
		MON_STORE
	} mon_state_type;

endpackage : phy_vendor_cfg_pkg

// ### phy_vendor_config_status_regs.sv
/*
 * Vendor configuration and status register bank: strap readback,
 * sensor monitor sequencer, link-up timers, decoder bypass and
 * low-power code-group settings and detection.
 * Assumes the management front end presents one-cycle read and write
 * strobes with a 16-bit extended address on the core clock, and that
 * sample, code and link inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module phy_vendor_config_status_regs
	import phy_vendor_cfg_pkg::*;
(
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	// Register access from the management front end
	input  wire logic [15:0]  reg_addr_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	input  wire logic [15:0]  reg_wdata_i,
	output logic      [15:0]  reg_rdata_o,
	output logic              reg_rvalid_o,
	// Strap pins
	input  wire logic         strap_tx_shift_i,
	input  wire logic         strap_rx_shift_i,
	input  wire logic         strap_sgmii_en_i,
	input  wire logic         strap_rgmii_en_i,
	input  wire logic [2:0]   strap_if_select_i,
	input  wire logic         link_role_strap_i,
	input  wire logic [4:0]   management_address_strap_i,
	input  wire logic         strap_managed_i,
	// Sensor monitor
	input  wire logic         link_up_i,
	input  wire logic         monitor_fsm_bypass_i,
	input  wire logic [15:0]  monitor_sample_i,
	input  wire logic [127:0] converter_debug_i,
	output logic              monitor_adc_clk_o,
	output logic              sensor_reset_o,
	output logic      [2:0]   sensor_select_o,
	output logic      [15:0]  monitor_result_o,
	output logic              monitor_busy_o,
	// Link control
	input  wire logic         break_link_active_i,
	output logic              fifo_reset_o,
	output logic              slave_send32_en_o,
	output logic              fec_decoder_skip_o,
	input  wire logic         linkup_timer_start_i,
	output logic              maxwait_expired_o,
	output logic              minwait_expired_o,
	// Low-power signalling
	output logic      [2:0]   outgoing_wake_code_o,
	output logic      [2:0]   outgoing_sleep_code_o,
	input  wire logic         rx_code_valid_i,
	input  wire logic [2:0]   rx_code_i,
	output logic              wake_received_o,
	output logic              sleep_received_o
);

	logic [15:0]   mon_gain, mon_decim, mon_run, break_timer;
	logic [15:0]   fec_decoder, lp_code_sel, lp_code_thr, maxwait;
	logic [15:0]   gig_link_ctrl, mon_readout, strap_one, strap_two;
	logic [15:0]   next_rdata, max_cnt;
	logic [13:0]   strap_meta, strap_sync;
	logic [1:0]    strap_wait, smp_cnt;
	logic          strap_done, sample_tick, wr_run, timer_run;
	mon_state_type mon_state;
	logic [4:0]    div_cnt;
	logic [17:0]   acc;
	logic [2:0]    sensor_iter;
	logic [10:0]   unit_cnt;
	logic [7:0]    min_cnt;
	logic [6:0]    wake_run, sleep_run;

	// Keep writable bits from the new value, the rest from the old
	function automatic logic [15:0] merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [15:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction : merge
	function automatic logic hit(input logic [15:0] ofs);
		hit = reg_wr_i && (reg_addr_i == ofs);
	endfunction : hit
	// Consecutive run counter that saturates at its top value
	function automatic logic [6:0] run_next(input logic [6:0] cnt,
		input logic match);
		run_next = !match ? 7'h00 : cnt == 7'h7f ? cnt : cnt + 7'h01;
	endfunction : run_next
	assign wr_run = hit(OFS_MON_RUN);

	// Plain read/write configuration registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			mon_gain      <= RST_MON_GAIN;
			mon_decim     <= RST_MON_DECIM;
			break_timer   <= RST_BREAK_TIMER;
			fec_decoder   <= RST_FEC_DECODER;
			lp_code_sel   <= RST_LP_CODE_SEL;
			lp_code_thr   <= RST_LP_CODE_THR;
			maxwait       <= RST_MAXWAIT;
			gig_link_ctrl <= RST_GIG_LINK_CTRL;
		end else begin
			if (hit(OFS_MON_GAIN))
				mon_gain <= reg_wdata_i;
			if (hit(OFS_MON_DECIM))
				mon_decim <= reg_wdata_i;
			if (hit(OFS_BREAK_TIMER))
				break_timer <= reg_wdata_i;
			if (hit(OFS_FEC_DECODER))
				fec_decoder <= reg_wdata_i;
			if (hit(OFS_LP_CODE_SEL))
				lp_code_sel <= merge(lp_code_sel, reg_wdata_i,
					WM_LP_CODE_SEL);
			if (hit(OFS_LP_CODE_THR))
				lp_code_thr <= merge(lp_code_thr, reg_wdata_i,
					WM_LP_CODE_THR);
			if (hit(OFS_MAXWAIT))
				maxwait <= reg_wdata_i;
			if (hit(OFS_GIG_LINK_CTRL))
				gig_link_ctrl <= merge(gig_link_ctrl, reg_wdata_i,
					WM_GIG_LINK_CTRL);
		end
	end

	// Run control; start clears itself one cycle after it is written
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			mon_run <= RST_MON_RUN;
		else if (wr_run)
			mon_run <= merge(mon_run, reg_wdata_i, WM_MON_RUN);
		else
			mon_run[B_START] <= 1'b0;
	end

	// Straps pass two flops, then are caught once after reset release
	always_ff @(posedge sys_clk_i) begin
		strap_meta <= {strap_tx_shift_i, strap_rx_shift_i,
			strap_sgmii_en_i, strap_rgmii_en_i, strap_if_select_i,
			link_role_strap_i, management_address_strap_i,
			strap_managed_i};
		strap_sync <= strap_meta;
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			strap_wait <= 2'h0;
			strap_done <= 1'b0;
			strap_one  <= 16'h0000;
			strap_two  <= 16'h0000;
		end else if (!strap_done) begin
			if (strap_wait == STRAP_SETTLE) begin
				strap_done <= 1'b1;
				strap_one  <= {strap_sync[13:10], 3'h0,
					strap_sync[9:7], strap_sync[6],
					strap_sync[5:1]};
				strap_two  <= {15'h0000, strap_sync[0]};
			end else
				strap_wait <= strap_wait + 2'h1;
		end
	end

	// Converter clock divider; the tick marks one sample per period
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || mon_run[B_MON_RST]) begin
			div_cnt           <= 5'h00;
			monitor_adc_clk_o <= 1'b0;
			sample_tick       <= 1'b0;
		end else begin
			sample_tick <= 1'b0;
			if ((mon_run[B_DIV_LO+1:B_DIV_LO] == 2'b00 &&
				div_cnt >= HALF_12M5 - 5'h01) ||
				(mon_run[B_DIV_LO+1:B_DIV_LO] == 2'b01 &&
				div_cnt >= HALF_6M25 - 5'h01) ||
				(div_cnt >= HALF_3M13 - 5'h01)) begin
				div_cnt           <= 5'h00;
				monitor_adc_clk_o <= ~monitor_adc_clk_o;
				sample_tick       <= monitor_adc_clk_o;
			end else
				div_cnt <= div_cnt + 5'h01;
		end
	end

	// Sensor monitor sequencer; the reset bit wins over everything
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || mon_run[B_MON_RST]) begin
			mon_state   <= MON_IDLE;
			smp_cnt     <= 2'h0;
			acc         <= 18'h00000;
			sensor_iter <= 3'h0;
		end else begin
			unique case (mon_state)
			MON_IDLE:
				if (mon_run[B_START] &&
					(link_up_i || mon_run[B_FORCE]))
					mon_state <= MON_DISCARD;
			MON_DISCARD: begin
				if (sample_tick) begin
					smp_cnt <= smp_cnt + 2'h1;
					if (smp_cnt == (mon_run[B_DISC4] ? 2'h3 : 2'h1)) begin
						smp_cnt   <= 2'h0;
						mon_state <= MON_AVERAGE;
					end
				end
			end
			MON_AVERAGE: begin
				if (sample_tick) begin
					acc     <= acc + {2'h0, monitor_sample_i};
					smp_cnt <= smp_cnt + 2'h1;
					if (smp_cnt == (mon_run[B_AVG4] ? 2'h3 : 2'h1))
						mon_state <= MON_STORE;
				end
			end
			MON_STORE: begin
				sensor_iter <= sensor_iter + 3'h1;
				smp_cnt     <= 2'h0;
				acc         <= 18'h00000;
				// Periodic mode loops without a fresh start request
				mon_state <= mon_run[B_PERIODIC] ? MON_DISCARD
					: MON_IDLE;
			end
			endcase
		end
	end

	// Result store; the average divides by two or four
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || (mon_run[B_HIST_CLR] && !wr_run))
			monitor_result_o <= 16'h0000;
		else if (mon_state == MON_STORE)
			monitor_result_o <= mon_run[B_AVG4] ? acc[17:2] : acc[16:1];
	end

	// Sensor controls; bypass hands them straight to software
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sensor_reset_o  <= 1'b1;
			sensor_select_o <= 3'h0;
			monitor_busy_o  <= 1'b0;
		end else if (monitor_fsm_bypass_i) begin
			sensor_reset_o  <= mon_decim[B_BYP_SENSOR_RST];
			sensor_select_o <= mon_decim[2:0];
			monitor_busy_o  <= 1'b0;
		end else begin
			sensor_reset_o  <= mon_state == MON_IDLE;
			sensor_select_o <= sensor_iter;
			monitor_busy_o  <= mon_state != MON_IDLE;
		end
	end

	// Debug readout follows the selector one cycle later
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			mon_readout <= 16'h0000;
		else
			mon_readout <= converter_debug_i[
				mon_decim[B_DBG_SEL_LO+2:B_DBG_SEL_LO]*16 +: 16];
	end

	// Link controls taken from configuration bits; fifo reset also needs break link active
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			fifo_reset_o          <= 1'b0;
			slave_send32_en_o     <= 1'b0;
			fec_decoder_skip_o    <= 1'b0;
			outgoing_wake_code_o  <= 3'h0;
			outgoing_sleep_code_o <= 3'h0;
		end else begin
			fifo_reset_o <= break_timer[B_FIFO_RST_BRK] &&
				break_link_active_i;
			// Software keeps this clear when fast retrain is on
			slave_send32_en_o  <= break_timer[B_SEND32];
			fec_decoder_skip_o <= fec_decoder[B_FEC_SKIP];
			outgoing_wake_code_o <=
				lp_code_sel[B_TX_WAKE_LO+2:B_TX_WAKE_LO];
			outgoing_sleep_code_o <=
				lp_code_sel[B_TX_SLEEP_LO+2:B_TX_SLEEP_LO];
		end
	end

	// Link-up timers in 16 us units; a new start restarts both
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || linkup_timer_start_i) begin
			unit_cnt          <= 11'h000;
			max_cnt           <= 16'h0000;
			min_cnt           <= 8'h00;
			timer_run         <= !rst_i;
			maxwait_expired_o <= 1'b0;
			minwait_expired_o <= 1'b0;
		end else if (timer_run) begin
			if (max_cnt >= maxwait)
				maxwait_expired_o <= 1'b1;
			if (min_cnt >= gig_link_ctrl[7:0])
				minwait_expired_o <= 1'b1;
			if (maxwait_expired_o && minwait_expired_o)
				timer_run <= 1'b0;
			if (unit_cnt == 11'(UNIT_CYCLES - 1)) begin
				unit_cnt <= 11'h000;
				if (max_cnt != 16'hffff)
					max_cnt <= max_cnt + 16'h0001;
				if (min_cnt != 8'hff)
					min_cnt <= min_cnt + 8'h01;
			end else
				unit_cnt <= unit_cnt + 11'h001;
		end
	end

	// Low-power code runs; a flag pulses when the run hits threshold
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wake_run         <= 7'h00;
			sleep_run        <= 7'h00;
			wake_received_o  <= 1'b0;
			sleep_received_o <= 1'b0;
		end else begin
			wake_received_o  <= 1'b0;
			sleep_received_o <= 1'b0;
			if (rx_code_valid_i) begin
				wake_run <= run_next(wake_run, rx_code_i ==
					lp_code_sel[B_RX_WAKE_LO+2:B_RX_WAKE_LO]);
				sleep_run <= run_next(sleep_run,
					rx_code_i == lp_code_sel[2:0]);
				if (run_next(wake_run, rx_code_i ==
					lp_code_sel[B_RX_WAKE_LO+2:B_RX_WAKE_LO]) ==
					lp_code_thr[B_WAKE_THR_LO+6:B_WAKE_THR_LO] &&
					wake_run != lp_code_thr[B_WAKE_THR_LO+6:B_WAKE_THR_LO])
					wake_received_o <= 1'b1;
				if (run_next(sleep_run, rx_code_i == lp_code_sel[2:0]) ==
					lp_code_thr[6:0] && sleep_run != lp_code_thr[6:0])
					sleep_received_o <= 1'b1;
			end
		end
	end

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		next_rdata = 16'h0000;
		unique case (reg_addr_i)
		OFS_STRAP_ONE:     next_rdata = strap_one;
		OFS_STRAP_TWO:     next_rdata = strap_two;
		OFS_MON_GAIN:      next_rdata = mon_gain;
		OFS_MON_DECIM:     next_rdata = mon_decim;
		OFS_MON_RUN:       next_rdata = mon_run;
		OFS_MON_READOUT:   next_rdata = mon_readout;
		OFS_BREAK_TIMER:   next_rdata = break_timer;
		OFS_FEC_DECODER:   next_rdata = fec_decoder;
		OFS_LP_CODE_SEL:   next_rdata = lp_code_sel;
		OFS_LP_CODE_THR:   next_rdata = lp_code_thr;
		OFS_MAXWAIT:       next_rdata = maxwait;
		OFS_GIG_LINK_CTRL: next_rdata = gig_link_ctrl;
		default:           next_rdata = 16'h0000;
		endcase
	end

	// Read data is registered and held until the next read
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			reg_rdata_o  <= 16'h0000;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
				reg_rdata_o <= next_rdata;
		end
	end

endmodule : phy_vendor_config_status_regs

// ### phy_vendor_regs_chk.sv
/* Port checker for the vendor configuration register bank.
   Assumes it is bound to phy_vendor_config_status_regs, one clock. */
`timescale 1ns/1ps
module phy_vendor_regs_chk
	import phy_vendor_cfg_pkg::*;
(
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        reg_rvalid_o,
	input wire logic        monitor_busy_o,
	input wire logic        break_link_active_i,
	input wire logic        fifo_reset_o,
	input wire logic        rx_code_valid_i,
	input wire logic        wake_received_o,
	input wire logic        sleep_received_o,
	input wire logic        linkup_timer_start_i,
	input wire logic        maxwait_expired_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// Read request at one offset, then its one-cycle answer
	sequence s_rd(logic [15:0] a);
		reg_rd_i && reg_addr_i == a;
	endsequence
	sequence s_ans;
		reg_rvalid_o;
	endsequence

	property p_unmapped;
		s_rd(16'h0400) |=> s_ans ##0 reg_rdata_o == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_strap_two;
		s_rd(OFS_STRAP_TWO) |=> s_ans ##0 reg_rdata_o[15:1] == 15'h0000;
	endproperty
	a_strap_two: assert property (p_strap_two)
		else $error("strap two reserved bits set");
	property p_strap_tm;
		s_rd(OFS_STRAP_ONE) |=> s_ans ##0 reg_rdata_o[11:9] == 3'h0;
	endproperty
	a_strap_tm: assert property (p_strap_tm)
		else $error("strap one test field set");
	property p_run_rsvd;
		s_rd(OFS_MON_RUN) |=> s_ans ##0 reg_rdata_o[15:9] == 7'h00;
	endproperty
	a_run_rsvd: assert property (p_run_rsvd)
		else $error("run control reserved bits set");
	property p_thr_rsvd;
		s_rd(OFS_LP_CODE_THR) |=> !reg_rdata_o[15] && !reg_rdata_o[7];
	endproperty
	a_thr_rsvd: assert property (p_thr_rsvd)
		else $error("threshold reserved bits set");
	// Reset bit written high drops the sequencer to idle
	property p_mon_reset;
		reg_wr_i && reg_addr_i == OFS_MON_RUN && reg_wdata_i[2]
			|-> ##[1:3] !monitor_busy_o;
	endproperty
	a_mon_reset: assert property (p_mon_reset)
		else $error("monitor not idle after reset bit");
	property p_fifo;
		!break_link_active_i |=> !fifo_reset_o;
	endproperty
	a_fifo: assert property (p_fifo)
		else $error("fifo reset outside break link");
	property p_wake_cause;
		$rose(wake_received_o) |-> $past(rx_code_valid_i);
	endproperty
	a_wake_cause: assert property (p_wake_cause)
		else $error("wake flag without code");
	property p_wake_pulse;
		wake_received_o |=> !wake_received_o;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake flag longer than a cycle");
	property p_sleep_cause;
		$rose(sleep_received_o) |-> $past(rx_code_valid_i);
	endproperty
	a_sleep_cause: assert property (p_sleep_cause)
		else $error("sleep flag without code");
	property p_max_clr;
		linkup_timer_start_i |=> !maxwait_expired_o;
	endproperty
	a_max_clr: assert property (p_max_clr)
		else $error("max wait not cleared by start");
endmodule : phy_vendor_regs_chk

bind phy_vendor_config_status_regs phy_vendor_regs_chk i_chk (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
	.monitor_busy_o(monitor_busy_o),
	.break_link_active_i(break_link_active_i),
	.fifo_reset_o(fifo_reset_o), .rx_code_valid_i(rx_code_valid_i),
	.wake_received_o(wake_received_o),
	.sleep_received_o(sleep_received_o),
	.linkup_timer_start_i(linkup_timer_start_i),
	.maxwait_expired_o(maxwait_expired_o)
);

// ### testbench.sv
/* Self-checking bench for the vendor configuration register bank.
   Assumes mgmt_host drives the strobe bus and the checker is bound. */
`timescale 1ns/1ps
module testbench;
	import phy_vendor_cfg_pkg::*;
	typedef struct {logic [15:0] a; logic [15:0] e;} row_type;
	logic         sys_clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
	logic         strap_tx_shift_i, strap_rx_shift_i, strap_sgmii_en_i;
	logic         strap_rgmii_en_i, link_role_strap_i, strap_managed_i;
	logic         link_up_i, monitor_fsm_bypass_i, monitor_adc_clk_o;
	logic         sensor_reset_o, monitor_busy_o, break_link_active_i;
	logic         fifo_reset_o, slave_send32_en_o, fec_decoder_skip_o;
	logic         linkup_timer_start_i, maxwait_expired_o;
	logic         minwait_expired_o, rx_code_valid_i;
	logic         wake_received_o, sleep_received_o;
	logic [15:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
	logic [15:0]  monitor_sample_i, monitor_result_o;
	logic [2:0]   strap_if_select_i, sensor_select_o, rx_code_i;
	logic [2:0]   outgoing_wake_code_o, outgoing_sleep_code_o;
	logic [4:0]   management_address_strap_i;
	logic [127:0] converter_debug_i;
	logic [3:0]   codes [11];
	int           fails, num_checks, cycles, n_wake, n_sleep;
	int           d1, d2, d3;
	row_type      rows [13];

	phy_vendor_config_status_regs i_dut (.*);
	mgmt_host i_host (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata_o),
		.reg_rvalid_i(reg_rvalid_o), .reg_addr_o(reg_addr_i),
		.reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.reg_wdata_o(reg_wdata_i));

	// Clock and hang guard
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cycles++;
		n_wake += wake_received_o;
		n_sleep += sleep_received_o;
		if (cycles == 20000) begin
			fails++;
			test_done();
		end
	end

	task check(input logic [15:0] seen, exp, input string m);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : check
	task rchk(input logic [15:0] a, exp);
		i_host.rd_word(a, rd);
		check(rd, exp, "read data");
	endtask : rchk
	task cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : cyc
	// Start a one-shot run and time it until the sequencer is idle
	task run_mon(input logic [15:0] d, output int t);
		i_host.wr_word(OFS_MON_RUN, d);
		rchk(OFS_MON_RUN, d & 16'hfffe);
		t = 0;
		while (monitor_busy_o === 1'b1 && t < 400) begin
			t++;
			cyc(1);
		end
		check(monitor_result_o, 16'h1234, "average");
	endtask : run_mon
	task test_done;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// Main sequence
	initial begin
		rows = '{'{16'h045d, 16'ha16a}, '{16'h045e, 16'h0001},
			'{16'h0467, 16'h0012}, '{16'h0468, 16'h0920},
			'{16'h046a, 16'h0094}, '{16'h047b, 16'h0a0a},
			'{16'h050a, 16'h112e}, '{16'h0510, 16'h2d50},
			'{16'h0514, 16'h08e3}, '{16'h0515, 16'h0808},
			'{16'h0518, 16'h17ce}, '{16'h0519, 16'h003d},
			'{16'h0400, 16'h0000}};
		codes = '{4'hb, 4'hb, 4'h3, 4'h9, 4'hb, 4'hb, 4'h0, 4'hb, 4'hc,
			4'hc, 4'h0};
		{strap_tx_shift_i, strap_rx_shift_i} = 2'b10;
		{strap_sgmii_en_i, strap_rgmii_en_i} = 2'b10;
		strap_if_select_i = 3'h5;
		link_role_strap_i = 1'b1;
		management_address_strap_i = 5'h0a;
		strap_managed_i = 1'b1;
		{link_up_i, monitor_fsm_bypass_i, break_link_active_i} = 3'b000;
		{linkup_timer_start_i, rx_code_valid_i} = 2'b00;
		rx_code_i = 3'h0;
		monitor_sample_i = 16'h1234;
		converter_debug_i = 128'h7007_6006_5005_4004_3003_2002_1001_0a0a;
		rst_i = 1'b1;
		cyc(4);
		rst_i <= 1'b0;
		cyc(8);
		check(sensor_reset_o, 16'h1, "sensor reset idle");
		check({outgoing_wake_code_o, outgoing_sleep_code_o}, 16'h23,
			"codes");
		foreach (rows[i]) rchk(rows[i].a, rows[i].e);
		$display("reset table done");
		strap_tx_shift_i <= 1'b0;
		management_address_strap_i <= 5'h0f;
		cyc(5);
		i_host.wr_word(OFS_STRAP_ONE, 16'h0000);
		rchk(OFS_STRAP_ONE, 16'ha16a);
		i_host.wr_word(OFS_LP_CODE_THR, 16'hffff);
		rchk(OFS_LP_CODE_THR, 16'h7f7f);
		i_host.wr_word(OFS_LP_CODE_SEL, 16'hfa1c);
		rchk(OFS_LP_CODE_SEL, 16'h0a1c);
		check({outgoing_wake_code_o, outgoing_sleep_code_o}, 16'h28,
			"codes");
		i_host.wr_word(OFS_LP_CODE_THR, 16'h0302);
		foreach (codes[i]) begin
			@(posedge sys_clk_i);
			{rx_code_valid_i, rx_code_i} <= codes[i];
		end
		cyc(3);
		check(16'(n_wake), 16'h1, "wake count");
		check(16'(n_sleep), 16'h1, "sleep count");
		$display("low power test done");
		break_link_active_i <= 1'b1;
		cyc(3);
		check(fifo_reset_o, 16'h1, "fifo reset");
		i_host.wr_word(OFS_BREAK_TIMER, 16'h0800);
		cyc(2);
		check({fifo_reset_o, slave_send32_en_o}, 16'h1, "link");
		i_host.wr_word(OFS_FEC_DECODER, 16'h8000);
		cyc(2);
		check(fec_decoder_skip_o, 16'h1, "decoder skip");
		monitor_fsm_bypass_i <= 1'b1;
		i_host.wr_word(OFS_MON_DECIM, 16'hb005);
		cyc(2);
		check({sensor_reset_o, sensor_select_o}, 16'hd, "bypass");
		rchk(OFS_MON_READOUT, 16'h3003);
		i_host.wr_word(OFS_MON_DECIM, 16'h3005);
		cyc(2);
		check(sensor_reset_o, 16'h0, "bypass release");
		monitor_fsm_bypass_i <= 1'b0;
		$display("link control test done");
		i_host.wr_word(OFS_MON_RUN, 16'h0001);
		cyc(4);
		check(monitor_busy_o, 16'h0, "start without link");
		run_mon(16'h0009, d1);
		run_mon(16'h00c9, d2);
		run_mon(16'h0029, d3);
		check({15'h0, d1 < 60}, 16'h1, "one shot");
		check({15'h0, d2 > d1 + 30}, 16'h1, "sample counts");
		check({15'h0, d3 > d1 + 30}, 16'h1, "clock divide");
		i_host.wr_word(OFS_MON_RUN, 16'h000b);
		cyc(150);
		check(monitor_busy_o, 16'h1, "periodic");
		// Fastest divider toggles every five core cycles
		rd[0] = monitor_adc_clk_o;
		cyc(5);
		check(monitor_adc_clk_o, {15'h0, !rd[0]}, "adc clock");
		i_host.wr_word(OFS_MON_RUN, 16'h0104);
		cyc(3);
		check(monitor_busy_o, 16'h0, "monitor reset");
		check(monitor_result_o, 16'h0, "hist clear");
		$display("monitor test done");
		i_host.wr_word(OFS_MAXWAIT, 16'h0002);
		i_host.wr_word(OFS_GIG_LINK_CTRL, 16'h0001);
		@(posedge sys_clk_i);
		linkup_timer_start_i <= 1'b1;
		@(posedge sys_clk_i);
		linkup_timer_start_i <= 1'b0;
		cyc(1990);
		check({maxwait_expired_o, minwait_expired_o}, 16'h0, "t0");
		cyc(20);
		check({maxwait_expired_o, minwait_expired_o}, 16'h1, "t1");
		cyc(2000);
		check({maxwait_expired_o, minwait_expired_o}, 16'h3, "t2");
		$display("timer test done");
		// Mid-run reset must catch the straps as they stand now
		rst_i <= 1'b1;
		cyc(2);
		rst_i <= 1'b0;
		cyc(6);
		rchk(OFS_STRAP_ONE, 16'h216f);
		$display("reset test done");
		test_done();
	end
endmodule : testbench
